/* File: clock_prescaler.sv */
`timescale 1ns/1ps
module clock_prescaler
  import timer_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst, // Async reset
  input wire logic run, // Divider advances only while counting
  input wire logic [CTRL_PSC_W-1:0] sel, // Divide by 1,4,16,64,...
  output logic tick // One-cycle count enable
);
  logic [13:0] div_r;
  logic [13:0] mask;

  always_comb begin
    unique case (sel)
      3'd0: mask = 14'h0000;
      3'd1: mask = 14'h0003;
      3'd2: mask = 14'h000f;
      3'd3: mask = 14'h003f;
      3'd4: mask = 14'h00ff;
      3'd5: mask = 14'h03ff;
      3'd6: mask = 14'h0fff;
      default: mask = 14'h3fff;
    endcase
  end

  // Divider clears while stopped, so the first period after start is whole
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_r <= '0;
    end else if (!run) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 14'h0001;
    end
  end

  assign tick = run && ((div_r & mask) == mask);
endmodule

/* File: pulse_sink.sv */
`timescale 1ns/1ps
module pulse_sink (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic pin, // Pulse in
  output logic [31:0] hi_w, // Last high width
  output logic [31:0] lo_w, // Last low width
  output logic [31:0] edges // Edge count
);
  logic last_r;
  logic [31:0] cnt_r;
  // Whole clocks only; the first width after a start is partial
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_r <= 1'b0;
      cnt_r <= 32'h1;
      hi_w <= 32'h0;
      lo_w <= 32'h0;
      edges <= 32'h0;
    end else if (pin != last_r) begin
      if (last_r) hi_w <= cnt_r;
      else lo_w <= cnt_r;
      last_r <= pin;
      cnt_r <= 32'h1;
      edges <= edges + 32'h1;
    end else begin
      cnt_r <= cnt_r + 32'h1;
    end
  end
endmodule

/* File: tb_top.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("Error %0t: got %h exp %h", $time, g, e); end end
module tb_top;
  import timer_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic rd_q = 1'b0;
  logic pin;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0;
  logic [15:0] rdata, n, x;
  logic [31:0] hi_w, lo_w, edges, e0;
  logic [15:0] exp_q[$];
  int mismatches = 0;
  int total_checks = 0;
  int d;
  always #2 clk = ~clk;
  toggle_pulse_timer dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .compare_output_pin(pin));
  pulse_sink sink (.clk(clk), .rst(rst), .pin(pin), .hi_w(hi_w), .lo_w(lo_w), .edges(edges));
  // Read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_q) begin
      x = exp_q.pop_front();
      `CHK(rdata, x)
    end
    rd_q <= rd_en;
  end
  task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    if (!w) exp_q.push_back(v);
    addr <= a;
    wdata <= v;
    wr_en <= w;
    rd_en <= !w;
    @(posedge clk);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask
  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    #100_000;
    mismatches++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'hd693_aa47));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    bus(0, ADDR_COMPARE_A, COMPARE_RESET);
    bus(0, ADDR_MODULE_STOP, 16'h1);
    bus(0, 4'hf, 16'h0);
    bus(1, ADDR_CTRL, 16'h20);
    bus(0, ADDR_CTRL, 16'h0);
    bus(1, ADDR_MODULE_STOP, 16'h0);
    bus(1, ADDR_COUNTER, 16'ha5c3);
    bus(0, ADDR_COUNTER, 16'ha5c3);
    $display("Test registers done");
    for (int s = 0; s < 3; s++) begin
      n = (s == 0) ? 16'h0 : 16'($urandom_range(9, 2));
      bus(1, ADDR_START, 16'h0);
      bus(1, ADDR_CTRL, 16'h20 | 16'(s));
      bus(1, ADDR_IO_CTRL, {12'h0, IO_TOGGLE});
      bus(1, ADDR_COMPARE_A, n);
      bus(1, ADDR_COUNTER, 16'h0);
      bus(1, ADDR_START, 16'h1);
      d = (4 ** s) * (int'(n) + 1);
      repeat (5 * d + 8) @(posedge clk);
      `CHK(hi_w, 32'(d))
      `CHK(lo_w, 32'(d))
    end
    $display("Test toggle periods done");
    bus(1, ADDR_CTRL, 16'h20);
    bus(1, ADDR_IO_CTRL, {12'h0, IO_HIGH});
    repeat (2 * int'(n) + 6) @(posedge clk);
    `CHK(pin, 1'b1)
    bus(1, ADDR_IO_CTRL, {12'h0, IO_LOW});
    repeat (2 * int'(n) + 6) @(posedge clk);
    `CHK(pin, 1'b0)
    $display("Test match levels done");
    bus(1, ADDR_IO_CTRL, {12'h0, IO_TOGGLE});
    bus(1, ADDR_START, 16'h0);
    repeat (2) @(posedge clk);
    e0 = edges;
    repeat (40) @(posedge clk);
    `CHK(edges, e0)
    bus(1, ADDR_COUNTER, 16'h0003);
    repeat (20) @(posedge clk);
    bus(0, ADDR_COUNTER, 16'h0003);
    $display("Test stop hold done");
    repeat (4) @(posedge clk);
    print_verdict();
  end
endmodule

/* File: timer_pkg.sv */
package timer_pkg;
  // Register addresses on the plain port
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_IO_CTRL = 4'h1;
  localparam logic [3:0] ADDR_COMPARE_A = 4'h2;
  localparam logic [3:0] ADDR_START = 4'h3;
  localparam logic [3:0] ADDR_COUNTER = 4'h4;
  localparam logic [3:0] ADDR_MODULE_STOP = 4'h5;
  localparam logic [3:0] ADDR_STATUS = 4'h6;

  localparam int CNT_W = 16;

  // Control register fields
  localparam int CTRL_PSC_LSB = 0;
  localparam int CTRL_PSC_W = 3;
  localparam int CTRL_CLR_LSB = 5;
  localparam int CTRL_CLR_W = 3;
  localparam logic [2:0] CLR_NONE = 3'h0;
  localparam logic [2:0] CLR_MATCH_A = 3'h1;

  // Output action on match
  localparam int IO_W = 4;
  localparam logic [3:0] IO_NONE = 4'h0;
  localparam logic [3:0] IO_LOW = 4'h1;
  localparam logic [3:0] IO_HIGH = 4'h2;
  localparam logic [3:0] IO_TOGGLE = 4'h3;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] COMPARE_RESET = 16'hffff;
  localparam logic MSTOP_RESET = 1'b1;

  // Nominal system clock figures
  localparam int SYS_CLK_HZ = 20_000_000;
  localparam int SYS_PERIOD_NS = 1_000_000_000 / SYS_CLK_HZ;
  localparam int MIN_PERIOD_NS = 100;
  localparam int MAX_PERIOD_NS = 3_270_000;
  localparam int MIN_CYCLES = MIN_PERIOD_NS / SYS_PERIOD_NS;
endpackage

/* File: timer_props.sv */
`timescale 1ns/1ps
module timer_props
  import timer_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic [3:0] addr, // Address
  input wire logic [15:0] wdata, // Write data
  input wire logic wr_en, // Write strobe
  input wire logic rd_en, // Read strobe
  input wire logic [15:0] rdata, // Read data
  input wire logic compare_output_pin // Pulse pin
);
  logic mstop_r, run_r, seen_r, pin_r;
  logic [7:0] ctrl_r;
  logic [3:0] io_r;
  logic [15:0] cmp_r;
  logic [16:0] gap_r;
  wire chg = compare_output_pin != pin_r;
  wire ok = !mstop_r && run_r && ctrl_r == 8'h20 && io_r == IO_TOGGLE;
  // Shadow of writes; the module stop gate drops the rest
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mstop_r <= MSTOP_RESET;
      run_r <= 1'b0;
      ctrl_r <= CTRL_RESET;
      io_r <= IO_NONE;
      cmp_r <= COMPARE_RESET;
    end else if (wr_en && addr == ADDR_MODULE_STOP) begin
      mstop_r <= wdata[0];
    end else if (wr_en && !mstop_r) begin
      if (addr == ADDR_START) run_r <= wdata[0];
      if (addr == ADDR_CTRL) ctrl_r <= wdata[7:0];
      if (addr == ADDR_IO_CTRL) io_r <= wdata[3:0];
      if (addr == ADDR_COMPARE_A) cmp_r <= wdata;
    end
  end
  // Any write restarts the watch, since the first half after it may be short
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_r <= 1'b0;
      seen_r <= 1'b0;
      gap_r <= 17'h0;
    end else begin
      pin_r <= compare_output_pin;
      seen_r <= !wr_en && (seen_r || chg);
      gap_r <= chg ? 17'h1 : gap_r + 17'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  half_period_a: assert property (ok && seen_r && chg |-> gap_r == {1'b0, cmp_r} + 17'h1)
    else $error("pin edge spacing wrong");
  no_late_toggle_a: assert property (ok && seen_r && !chg |-> gap_r <= {1'b0, cmp_r})
    else $error("pin edge missing");
  stopped_hold_a: assert property (!run_r && !$past(run_r) |-> !chg)
    else $error("pin moved while stopped");
  idle_rdata_a: assert property (!$past(rd_en) |-> rdata == 16'h0)
    else $error("read data without read");
  unmapped_read_a: assert property ($past(rd_en) && $past(addr) > ADDR_STATUS |-> rdata == 16'h0)
    else $error("unmapped read not zero");
  compare_read_a: assert property ($past(rd_en) && $past(addr) == ADDR_COMPARE_A |-> rdata == cmp_r)
    else $error("compare readback wrong");
  stop_read_a: assert property ($past(rd_en) && $past(addr) == ADDR_MODULE_STOP |-> rdata[0] == mstop_r)
    else $error("module stop readback wrong");
  high_level_a: assert property (chg && io_r == IO_HIGH && $past(io_r) == IO_HIGH |-> compare_output_pin)
    else $error("pin not driven high on match");
endmodule
bind toggle_pulse_timer timer_props props (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
  .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .compare_output_pin(compare_output_pin));

/* File: toggle_pulse_timer.sv */
`timescale 1ns/1ps
// Summary of operation
// - The channel counter is 16 bits and counts periods of the selected counter clock.
// - With the clear source set to match A, a match between counter and compare register A clears the counter to zero.
// - In toggle mode the compare output pin inverts on every match with register A.
// - Once started the pin keeps toggling from hardware matches with no software help.
// - Toggle plus clear-on-match gives equal high and low times.
// - Output periods from a few clocks up to 2^17 counter clocks are reachable.
// - Output period equals twice the sum of the programmed value and one, times the counter clock period.
// - The control register picks the counter clock and the clear source.
// - The I/O control register picks the pin level taken on a match, toggle included.
// - The start bit runs the counter when set and stops it when cleared.
module toggle_pulse_timer
  import timer_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst, // Async reset, active high
  input wire logic [3:0] addr, // Register address
  input wire logic [15:0] wdata, // Write data
  input wire logic wr_en, // Write strobe
  input wire logic rd_en, // Read strobe
  output logic [15:0] rdata, // Read data, cycle after strobe
  output logic compare_output_pin // Generated pulse
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] timer_control_reg_r;
  logic [IO_W-1:0] io_control_reg_r;
  logic [CNT_W-1:0] general_compare_reg_a_r;
  logic counter_start_reg_r;
  logic module_stop_control_r;
  logic [CNT_W-1:0] channel_counter_r;
  logic [CNT_W-1:0] channel_counter_nxt;
  logic match_seen_r;
  logic pin_r;
  logic pin_nxt;
  logic tick;
  logic match;
  logic running;
  logic wr_counter;

  // Module stop freezes the channel and blocks its configuration
  assign running = counter_start_reg_r && !module_stop_control_r;
  assign wr_counter = wr_en && (addr == ADDR_COUNTER) && !module_stop_control_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      module_stop_control_r <= MSTOP_RESET;
    end else if (wr_en && addr == ADDR_MODULE_STOP) begin
      module_stop_control_r <= wdata[0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timer_control_reg_r <= CTRL_RESET;
    end else if (wr_en && addr == ADDR_CTRL && !module_stop_control_r) begin
      timer_control_reg_r <= wdata[7:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      io_control_reg_r <= IO_NONE;
    end else if (wr_en && addr == ADDR_IO_CTRL && !module_stop_control_r) begin
      io_control_reg_r <= wdata[IO_W-1:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      general_compare_reg_a_r <= COMPARE_RESET;
    end else if (wr_en && addr == ADDR_COMPARE_A && !module_stop_control_r) begin
      general_compare_reg_a_r <= wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      counter_start_reg_r <= 1'b0;
    end else if (wr_en && addr == ADDR_START && !module_stop_control_r) begin
      counter_start_reg_r <= wdata[0];
    end
  end

  // ----------------------------------------------------------------
  // Counter clock selection
  // ----------------------------------------------------------------
  clock_prescaler u_prescaler (
    .clk(clk),
    .rst(rst),
    .run(running),
    .sel(timer_control_reg_r[CTRL_PSC_LSB +: CTRL_PSC_W]),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // Counter and compare
  // ----------------------------------------------------------------
  // Match is judged on the counter clock edge, so a value of N spans N+1 counts
  assign match = tick && (channel_counter_r == general_compare_reg_a_r);

  always_comb begin
    channel_counter_nxt = channel_counter_r;
    if (match && timer_control_reg_r[CTRL_CLR_LSB +: CTRL_CLR_W] == CLR_MATCH_A) begin
      channel_counter_nxt = '0;
    end else if (tick) begin
      channel_counter_nxt = channel_counter_r + 16'h0001;
    end
  end

  // A software write to the counter wins over counting in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      channel_counter_r <= '0;
    end else if (wr_counter) begin
      channel_counter_r <= wdata;
    end else begin
      channel_counter_r <= channel_counter_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Output pin
  // ----------------------------------------------------------------
  always_comb begin
    pin_nxt = pin_r;
    if (match) begin
      unique case (io_control_reg_r)
        IO_LOW: pin_nxt = 1'b0;
        IO_HIGH: pin_nxt = 1'b1;
        IO_TOGGLE: pin_nxt = ~pin_r;
        default: pin_nxt = pin_r;
      endcase
    end
  end

  // Pin runs off hardware matches alone; no per-edge software action
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_r <= 1'b0;
    end else begin
      pin_r <= pin_nxt;
    end
  end

  assign compare_output_pin = pin_r;

  // Sticky match flag; set wins over a clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      match_seen_r <= 1'b0;
    end else if (match) begin
      match_seen_r <= 1'b1;
    end else if (wr_en && addr == ADDR_STATUS && wdata[0]) begin
      match_seen_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else if (rd_en) begin
      unique case (addr)
        ADDR_CTRL: rdata <= {8'h00, timer_control_reg_r};
        ADDR_IO_CTRL: rdata <= {12'h000, io_control_reg_r};
        ADDR_COMPARE_A: rdata <= general_compare_reg_a_r;
        ADDR_START: rdata <= {15'h0000, counter_start_reg_r};
        ADDR_COUNTER: rdata <= channel_counter_r;
        ADDR_MODULE_STOP: rdata <= {15'h0000, module_stop_control_r};
        ADDR_STATUS: rdata <= {14'h0000, pin_r, match_seen_r};
        default: rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end
endmodule
